/* rtl/safety_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 40 MHz hclk, 32-bit AHB-Lite register words.
// Notes:   Definitions only.
`ifndef SAFETY_DEFINES_SVH
`define SAFETY_DEFINES_SVH
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS    25
`define MS_PERIOD_NS     1000000
`define MS_CYCLES        (`MS_PERIOD_NS / `CLK_PERIOD_NS)
`define MS_PER_S         10'd999
`define IN_DELAY_MIN_MS  9'd10
`define RS_DELAY_MIN_S   6'd2
`define RS_DELAY_MAX_S   6'd60
`define FB_CHECK_MS      9'd300
// ------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ------------------------------------------------------------
`define OFS_CTRL         3'h0
`define OFS_RS_DELAY     3'h1
`define OFS_IN_DELAY     3'h2
`define OFS_STATUS       3'h3
`define OFS_LINK         3'h4
`define OFS_IRQ_STATUS   3'h5
`define OFS_IRQ_MASK     3'h6
// ------------------------------------------------------------
// Control fields and reset values
// ------------------------------------------------------------
`define CTRL_ONE_OF_N    0
`define CTRL_EXTERNAL    1
`define CTRL_FB_CHECK    2
`define CTRL_MODE_LO     3
`define CTRL_MODE_HI     4
`define CTRL_RESET       5'h10
`define RS_DELAY_RESET   6'h02
`define IN_DELAY_RESET   9'h00A
// ------------------------------------------------------------
// Interrupt bits and display codes
// ------------------------------------------------------------
`define IRQ_INPUT_ERR    0
`define IRQ_FIELD_BREAK  1
`define IRQ_FB_FAULT     2
`define IRQ_PAIR_ON      3
`define CODE_NONE        8'h00
`define CODE_INPUT_ERR   8'h31
`define CODE_FB_FAULT    8'h35
`endif

/* rtl/safety_pkg.sv */
// Purpose: Types shared by the decode and restart block.
// Assumes: Constants come from safety_defines.svh.
// Notes:   Types only.
package safety_pkg;
   // Restart modes
   typedef enum logic [1:0] {
      RS_NONE      = 2'h0,
      RS_DELAY     = 2'h1,
      RS_INTERLOCK = 2'h2
   } restart_mode_t;
   // Output pair states, one-hot
   typedef enum logic [5:0] {
      ST_OFF   = 6'b000001,
      ST_ON    = 6'b000010,
      ST_DELAY = 6'b000100,
      ST_WAIT  = 6'b001000,
      ST_FAULT = 6'b010000,
      ST_LOCK  = 6'b100000
   } pair_state_t;
   // Field status from the scan core, 1 = clear (prot_allocated: 1 = allocated)
   typedef struct packed {
      logic prot_allocated;
      logic prot_clear;
      logic warn1_clear;
      logic warn2_clear;
   } fields_t;
   // Decoded static inputs
   typedef struct packed {
      logic       logical_a;
      logic       logical_b;
      logic [2:0] case_num;
      logic       input_error;
   } decoded_t;
   // Frame contents for the safety link
   typedef struct packed {
      logic send_fields;
      logic pair_active;
      logic prot_clear;
      logic warn1_clear;
      logic warn2_clear;
   } link_t;
   // Indicator LEDs
   typedef struct packed {
      logic green;
      logic red;
      logic reset_required;
   } leds_t;
endpackage : safety_pkg

/* rtl/safety_input_decode_and_restart.sv */
// Purpose: Static input decode and output switching pair control.
// Assumes: Field status comes from logic on hclk; pins are asynchronous.
// Notes:   Registers over AHB-Lite, zero wait states, always OKAY.
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "safety_defines.svh"

module safety_input_decode_and_restart #(
   parameter int unsigned MS_CYCLES = `MS_CYCLES
) (
   // Clock and reset
   input  wire  logic                  hclk,
   input  wire  logic                  hresetn,
   // AHB-Lite slave
   input  wire  logic                  hsel,
   input  wire  logic [31:0]           haddr,
   input  wire  logic [1:0]            htrans,
   input  wire  logic                  hwrite,
   input  wire  logic [2:0]            hsize,
   input  wire  logic [31:0]           hwdata,
   input  wire  logic                  hready,
   output logic                        hreadyout,
   output logic                        hresp,
   output logic [31:0]                 hrdata,
   // Control input pins
   input  wire  logic                  input_a_channel_one,
   input  wire  logic                  input_a_channel_two,
   input  wire  logic                  input_b_channel_one,
   input  wire  logic                  input_b_channel_two,
   // Operator reset and contactor feedback pins
   input  wire  logic                  operator_reset,
   input  wire  logic                  contactor_released,
   // Field status from the scan core
   input  wire  safety_pkg::fields_t   fields,
   // Results
   output logic                        output_switching_pair,
   output safety_pkg::decoded_t        decoded,
   output safety_pkg::link_t           safety_link,
   output safety_pkg::leds_t           leds,
   output logic [7:0]                  error_code,
   output logic                        irq
);
   import safety_pkg::*;
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  pin_meta;
      logic [3:0]  pin_sync;
      logic        rst_meta;
      logic        rst_sync;
      logic        rst_prev;
      logic        fb_meta;
      logic        fb_sync;
      logic [3:0]  last;
      logic [8:0]  settle;
      logic [3:0]  eval;
      logic [15:0] div;
      logic [9:0]  ms_in_s;
      pair_state_t pair;
      logic [5:0]  secs;
      logic [8:0]  fb_ms;
      logic [4:0]  ctrl;
      logic [5:0]  rs_delay;
      logic [8:0]  in_delay;
      logic [3:0]  irq_status;
      logic [3:0]  irq_mask;
      logic        a_wr;
      logic [2:0]  a_idx;
      logic [31:0] rdata;
      logic [7:0]  code;
   } core_t;
   core_t st;
   core_t next_st;
   // ------------------------------------------------------------
   // Combinational decode
   // ------------------------------------------------------------
   logic          ms_tick;
   logic          s_tick;
   decoded_t      dec;
   restart_mode_t mode;
   logic          prot_ok;
   logic          go;
   logic          fb_ok;
   logic          fb_fault;
   logic          rst_press;
   logic [3:0]    events;
   logic [3:0]    w1c;
   logic [31:0]   rd_mux;
   logic          take;
   // Time base: 1 ms tick and 1 s tick
   assign ms_tick = (st.div == 16'(MS_CYCLES - 1));
   assign s_tick  = ms_tick && (st.ms_in_s == `MS_PER_S);
   // Restart mode; the spare code is treated as interlock
   always_comb begin
      case (st.ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO])
         2'h0:    mode = RS_NONE;
         2'h1:    mode = RS_DELAY;
         default: mode = RS_INTERLOCK;
      endcase
   end
   // Input decode on the evaluated channels {b2, b1, a2, a1}
   always_comb begin
      dec = '0;
      if (st.ctrl[`CTRL_ONE_OF_N]) begin
         case (st.eval)
            4'h1:    dec.case_num = 3'h1;
            4'h2:    dec.case_num = 3'h2;
            4'h4:    dec.case_num = 3'h3;
            4'h8:    dec.case_num = 3'h4;
            default: dec.input_error = 1'b1;
         endcase
      end else begin
         dec.logical_a   = st.eval[1];
         dec.logical_b   = st.eval[3];
         dec.input_error = (st.eval[0] == st.eval[1]) ||
                           (st.eval[2] == st.eval[3]);
      end
   end
   assign prot_ok = fields.prot_clear || !fields.prot_allocated;
   // remote pair leaves the local pair off
   assign go      = prot_ok && !dec.input_error && !st.ctrl[`CTRL_EXTERNAL];
   // contactor must be released before any ON
   assign fb_ok   = !st.ctrl[`CTRL_FB_CHECK] || st.fb_sync;
   // released contact expected after the check time
   assign fb_fault = st.ctrl[`CTRL_FB_CHECK] && !st.fb_sync &&
                     (st.fb_ms >= `FB_CHECK_MS);
   assign rst_press = st.rst_sync && !st.rst_prev;
   // Bus address phase taken
   assign take = hsel && hready && htrans[1];
   // Read data for the register being addressed
   always_comb begin
      rd_mux = '0;
      case (haddr[4:2])
         `OFS_CTRL:       rd_mux = {27'h0, st.ctrl};
         `OFS_RS_DELAY:   rd_mux = {26'h0, st.rs_delay};
         `OFS_IN_DELAY:   rd_mux = {23'h0, st.in_delay};
         `OFS_STATUS:     rd_mux = {16'h0, st.pair, st.eval,
                                    dec.case_num, dec.logical_b,
                                    dec.logical_a, dec.input_error};
         `OFS_LINK:       rd_mux = {27'h0, safety_link};
         `OFS_IRQ_STATUS: rd_mux = {28'h0, st.irq_status};
         `OFS_IRQ_MASK:   rd_mux = {28'h0, st.irq_mask};
         default:         rd_mux = '0;
      endcase
      if (haddr[31:5] != 27'h0) begin
         rd_mux = '0;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      events  = '0;
      w1c     = '0;
      // Two-stage synchronisers
      next_st.pin_meta = {input_b_channel_two, input_b_channel_one,
                          input_a_channel_two, input_a_channel_one};
      next_st.pin_sync = st.pin_meta;
      next_st.rst_meta = operator_reset;
      next_st.rst_sync = st.rst_meta;
      next_st.rst_prev = st.rst_sync;
      next_st.fb_meta  = contactor_released;
      next_st.fb_sync  = st.fb_meta;
      // Millisecond divider and second counter
      if (ms_tick) begin
         next_st.div = '0;
         if (s_tick) begin
            next_st.ms_in_s = '0;
         end else begin
            next_st.ms_in_s = st.ms_in_s + 10'h001;
         end
      end else begin
         next_st.div = st.div + 16'h0001;
      end
      // wait for stable inputs before evaluating
      if (st.pin_sync != st.last) begin
         next_st.last   = st.pin_sync;
         next_st.settle = '0;
      end else if (st.settle >= st.in_delay) begin
         next_st.eval = st.last;
      end else if (ms_tick) begin
         next_st.settle = st.settle + 9'h001;
      end
      // Feedback check timer runs while the pair is off
      if (st.pair == ST_ON) begin
         next_st.fb_ms = '0;
      end else if (ms_tick && st.fb_ms < `FB_CHECK_MS) begin
         next_st.fb_ms = st.fb_ms + 9'h001;
      end
      // Output pair state machine
      case (st.pair)
         ST_ON: begin
            // off as soon as the field is interrupted
            if (!go) begin
               next_st.pair  = ST_OFF;
               next_st.fb_ms = '0;
               events[`IRQ_FIELD_BREAK] = 1'b1;
            end
         end
         ST_OFF: begin
            if (go) begin
               case (mode)
                  RS_NONE: begin
                     if (fb_ok) begin
                        next_st.pair = ST_ON;
                        events[`IRQ_PAIR_ON] = 1'b1;
                     end
                  end
                  RS_DELAY: begin
                     next_st.pair = ST_DELAY;
                     next_st.secs = '0;
                  end
                  default: begin
                     next_st.pair = ST_WAIT;
                  end
               endcase
            end
         end
         ST_DELAY: begin
            if (!go) begin
               next_st.pair = ST_OFF;
               next_st.secs = '0;
            end else if (st.secs > st.rs_delay) begin
               // one tick more, as the first free-running tick may come at once
               if (fb_ok) begin
                  next_st.pair = ST_ON;
                  events[`IRQ_PAIR_ON] = 1'b1;
               end
            end else if (s_tick) begin
               next_st.secs = st.secs + 6'h01;
            end
         end
         ST_WAIT: begin
            if (!go) begin
               next_st.pair = ST_OFF;
            end else if (rst_press && fb_ok) begin
               next_st.pair = ST_ON;
               events[`IRQ_PAIR_ON] = 1'b1;
            end
         end
         ST_FAULT: begin
            // Cleared by reset once the contactor has dropped out
            if (rst_press && st.fb_sync) begin
               next_st.pair = ST_WAIT;
               next_st.code = `CODE_NONE;
            end
         end
         ST_LOCK: begin
            // Only a device reset leaves lock-out
            next_st.pair = ST_LOCK;
         end
         default: begin
            next_st.pair = ST_OFF;
         end
      endcase
      // Contactor fault overrides the off-side states
      if (fb_fault && (st.pair == ST_OFF || st.pair == ST_DELAY ||
                       st.pair == ST_WAIT)) begin
         events[`IRQ_FB_FAULT] = 1'b1;
         next_st.code          = `CODE_FB_FAULT;
         if (mode == RS_INTERLOCK) begin
            next_st.pair = ST_FAULT;
         end else begin
            next_st.pair = ST_LOCK;
         end
      end
      // Input error code while no contactor fault is shown
      if (next_st.code != `CODE_FB_FAULT) begin
         next_st.code = dec.input_error ? `CODE_INPUT_ERR : `CODE_NONE;
      end
      events[`IRQ_INPUT_ERR] = dec.input_error;
      // Bus write in the data phase
      if (st.a_wr) begin
         case (st.a_idx)
            `OFS_CTRL: begin
               next_st.ctrl = hwdata[4:0];
            end
            `OFS_RS_DELAY: begin
               // keep the delay within 2 to 60 s
               if (hwdata[31:6] != 26'h0 || hwdata[5:0] > `RS_DELAY_MAX_S) begin
                  next_st.rs_delay = `RS_DELAY_MAX_S;
               end else if (hwdata[5:0] < `RS_DELAY_MIN_S) begin
                  next_st.rs_delay = `RS_DELAY_MIN_S;
               end else begin
                  next_st.rs_delay = hwdata[5:0];
               end
            end
            `OFS_IN_DELAY: begin
               // no shorter than the base delay
               if (hwdata[31:9] == 23'h0 && hwdata[8:0] >= `IN_DELAY_MIN_MS) begin
                  next_st.in_delay = hwdata[8:0];
               end else if (hwdata[31:9] != 23'h0) begin
                  next_st.in_delay = 9'h1FF;
               end else begin
                  next_st.in_delay = `IN_DELAY_MIN_MS;
               end
            end
            `OFS_IRQ_STATUS: begin
               w1c = hwdata[3:0];
            end
            `OFS_IRQ_MASK: begin
               next_st.irq_mask = hwdata[3:0];
            end
            default: begin
               next_st.irq_mask = st.irq_mask;
            end
         endcase
      end
      // Sticky status: a new event wins over the clear
      next_st.irq_status = (st.irq_status & ~w1c) | events;
      // Address phase capture and read data
      next_st.a_wr  = take && hwrite && (haddr[31:5] == 27'h0);
      next_st.a_idx = haddr[4:2];
      if (take && !hwrite) begin
         next_st.rdata = rd_mux;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st          <= '0;
         st.pair     <= ST_OFF;
         st.ctrl     <= `CTRL_RESET;
         st.rs_delay <= `RS_DELAY_RESET;
         st.in_delay <= `IN_DELAY_RESET;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Bus answers at once and never errors
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = st.rdata;

   // Pair and indicators
   assign output_switching_pair = (st.pair == ST_ON);
   assign leds.green            = (st.pair == ST_ON);
   assign leds.red              = (st.pair != ST_ON);
   assign leds.reset_required   = (st.pair == ST_WAIT) || (st.pair == ST_FAULT);
   assign error_code            = st.code;
   assign decoded               = dec;

   // field set status sent when the remote pair is used
   assign safety_link.send_fields = st.ctrl[`CTRL_EXTERNAL];
   // unused local pair reported as active
   assign safety_link.pair_active = st.ctrl[`CTRL_EXTERNAL] || (st.pair == ST_ON);
   // raw field bits, not held by restart gating
   assign safety_link.prot_clear  = prot_ok;
   assign safety_link.warn1_clear = fields.warn1_clear;
   assign safety_link.warn2_clear = fields.warn2_clear;

   // Level interrupt from unmasked sticky bits
   assign irq = |(st.irq_status & st.irq_mask);

endmodule : safety_input_decode_and_restart

/* verification/safety_input_decode_and_restart_sva.sv */
// Purpose: Port assertions for the decode and restart block.
// Assumes: One hclk domain, hresetn active low.
// Notes:   Bound to the design at the foot of this file.
`timescale 1ns/1ps
`include "safety_defines.svh"
module safety_input_decode_and_restart_sva #(
   parameter int unsigned MS_CYCLES = 40
) (
   // Clock, reset and bus answer
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hreadyout,
   input wire logic                 hresp,
   // Field status and results
   input wire safety_pkg::fields_t  fields,
   input wire logic                 output_switching_pair,
   input wire safety_pkg::decoded_t decoded,
   input wire safety_pkg::link_t    safety_link,
   input wire logic [7:0]           error_code
);
   import safety_pkg::*;
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic go_field;
   // An unallocated field counts as clear
   assign go_field = fields.prot_clear | ~fields.prot_allocated;
   a_bus_okay:
      assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
   a_pair_off_field:
      assert property (!go_field |=> !output_switching_pair) else $error("pair on in field");
   a_pair_on_clear:
      assert property ($rose(output_switching_pair) |-> $past(go_field)) else $error("pair rose");
   a_link_prot:
      assert property (safety_link.prot_clear == go_field) else $error("link prot bit wrong");
   a_link_warn:
      assert property (safety_link.warn1_clear == fields.warn1_clear
         && safety_link.warn2_clear == fields.warn2_clear) else $error("link warn bits wrong");
   a_remote_active:
      assert property (safety_link.send_fields |-> safety_link.pair_active
         ##1 !output_switching_pair) else $error("remote pair state wrong");
   a_case_valid:
      assert property (decoded.case_num != 3'h0 |-> decoded.case_num <= 3'h4
         && !decoded.input_error) else $error("case number invalid");
   a_error_holds:
      assert property (decoded.input_error |=> !output_switching_pair) else $error("pair on err");
   a_fault_off:
      assert property ($rose(error_code == `CODE_FB_FAULT) |-> !output_switching_pair)
         else $error("fault code with pair on");
endmodule : safety_input_decode_and_restart_sva
bind safety_input_decode_and_restart safety_input_decode_and_restart_sva #(
   .MS_CYCLES(MS_CYCLES)) sva_inst (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .fields(fields), .output_switching_pair(output_switching_pair),
   .decoded(decoded), .safety_link(safety_link), .error_code(error_code));

/* verification/machine_controller_model.sv */
// Purpose: Machine controller and contactor on the far side of the block.
// Assumes: Contactor drops out two cycles after the pair goes OFF.
// Notes:   A welded contactor appears only when the bench asks.
`timescale 1ns/1ps
module machine_controller_model (
   // Clock
   input  wire logic       hclk,
   // Bench requests
   input  wire logic [3:0] pattern,
   input  wire logic       stuck,
   input  wire logic       press,
   // Pair from the block
   input  wire logic       output_switching_pair,
   // Pins toward the block
   output logic            input_a_channel_one,
   output logic            input_a_channel_two,
   output logic            input_b_channel_one,
   output logic            input_b_channel_two,
   output logic            operator_reset,
   output logic            contactor_released
);
   logic [1:0] drop;
   // held until the bench changes it
   assign {input_b_channel_two, input_b_channel_one} = pattern[3:2];
   assign {input_a_channel_two, input_a_channel_one} = pattern[1:0];
   // reset switch pressed on request only
   assign operator_reset = press;
   // Contactor lags the pair; a weld keeps it pulled in
   always_ff @(posedge hclk) begin
      drop <= {drop[0], ~output_switching_pair};
   end
   assign contactor_released = drop[1] & ~stuck;
endmodule : machine_controller_model

/* verification/testbench.sv */
// Purpose: Self-checking bench for the decode and restart block.
// Assumes: MS_CYCLES shortened to 8 so a second is 8000 cycles.
// Notes:   Registers reached through an AHB-Lite master task.
`timescale 1ns/1ps
module testbench;
   import safety_pkg::*;
   localparam int MS = 8;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, pair;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  pattern;
   logic stuck, press, a1, a2, b1, b2, rst_pin, released;
   logic [7:0]  error_code;
   fields_t     fields;
   decoded_t    decoded;
   link_t       safety_link;
   leds_t       leds;
   int n_mismatch, samples_checked;
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, got, exp); end end
   // ------------------------------------------------------------
   // Block, partner and clock
   // ------------------------------------------------------------
   safety_input_decode_and_restart #(.MS_CYCLES(MS)) safety_input_decode_and_restart_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .input_a_channel_one(a1),
      .input_a_channel_two(a2), .input_b_channel_one(b1), .input_b_channel_two(b2),
      .operator_reset(rst_pin), .contactor_released(released), .fields(fields),
      .output_switching_pair(pair), .decoded(decoded), .safety_link(safety_link),
      .leds(leds), .error_code(error_code), .irq(irq));
   machine_controller_model machine_controller_model_inst (.hclk(hclk), .pattern(pattern),
      .stuck(stuck), .press(press), .output_switching_pair(pair), .input_a_channel_one(a1),
      .input_a_channel_two(a2), .input_b_channel_one(b1), .input_b_channel_two(b2),
      .operator_reset(rst_pin), .contactor_released(released));
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   // ------------------------------------------------------------
   // Bus and timing tasks
   // ------------------------------------------------------------
   task automatic bus(input logic we, input logic [31:0] a, wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= we;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [31:0] a, wd);
      logic [31:0] x;
      bus(1'b1, a, wd, x);
   endtask : wr
   task automatic ms(input int n);
      repeat (n * MS) @(posedge hclk);
   endtask : ms
   task automatic conclude();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      bus(1'b0, 32'h0, 32'h0, d); `CHECK(d, 32'h10)
      bus(1'b0, 32'h8, 32'h0, d); `CHECK(d, 32'hA)
      wr(32'h4, 32'h3D);
      bus(1'b0, 32'h4, 32'h0, d); `CHECK(d, 32'h3C)
      wr(32'h4, 32'h2);
      wr(32'h20, 32'hFFFF_FFFF);
      bus(1'b0, 32'h20, 32'h0, d); `CHECK(d, 32'h0)
   endtask : t_regs
   task automatic t_decode();
      logic [3:0] p[10] = '{4'h5, 4'hA, 4'h7, 4'h4, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h3};
      logic [2:0] c[10] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0};
      logic       e[10] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1};
      for (int i = 0; i < 10; i++) begin
         if (i == 4) wr(32'h0, 32'h1);
         pattern <= p[i];
         ms(13);
         `CHECK(decoded.input_error, e[i])
         `CHECK(decoded.case_num, c[i])
         `CHECK(error_code, e[i] ? 8'h31 : 8'h00)
         if (i < 2) `CHECK(decoded.logical_a, p[i][1])
         if (i < 2) `CHECK(decoded.logical_b, p[i][3])
      end
      wr(32'h0, 32'h0);
      pattern <= 4'h5;
      ms(13);
      pattern <= 4'h7;
      ms(5);
      `CHECK(decoded.input_error, 1'b0)
      pattern <= 4'h5;
      ms(13);
   endtask : t_decode
   task automatic t_none();
      fields <= 4'hF;
      wr(32'h18, 32'h2);
      wr(32'h14, 32'hF);
      `CHECK(pair, 1'b1)
      bus(1'b0, 32'hC, 32'h0, d); `CHECK(d, 32'h940)
      fields <= 4'hB;
      repeat (3) @(posedge hclk);
      `CHECK(pair, 1'b0)
      `CHECK(safety_link.prot_clear, 1'b0)
      `CHECK(leds.red, 1'b1)
      `CHECK(irq, 1'b1)
      fields <= 4'hF;
      wr(32'h14, 32'h2);
      wr(32'h18, 32'h0);
      `CHECK(pair, 1'b1)
      `CHECK(irq, 1'b0)
      fields <= 4'hB;
      repeat (3) @(posedge hclk);
      fields <= 4'h3;
      repeat (3) @(posedge hclk);
      `CHECK(irq, 1'b0)
      `CHECK(safety_link.prot_clear, 1'b1)
      `CHECK(pair, 1'b1)
      wr(32'h18, 32'h2);
      repeat (2) @(posedge hclk);
      `CHECK(irq, 1'b1)
   endtask : t_none
   task automatic t_modes();
      wr(32'h0, 32'h2);
      fields <= 4'hB;
      repeat (3) @(posedge hclk);
      `CHECK(pair, 1'b0)
      `CHECK(safety_link.send_fields, 1'b1)
      `CHECK(safety_link.pair_active, 1'b1)
      `CHECK(safety_link.prot_clear, 1'b0)
      fields <= 4'hF;
      wr(32'h0, 32'h10);
      ms(2);
      `CHECK(pair, 1'b0)
      press <= 1'b1;
      ms(1);
      press <= 1'b0;
      `CHECK(pair, 1'b1)
      `CHECK(leds.green, 1'b1)
      wr(32'h0, 32'h8);
      fields <= 4'hB;
      ms(1);
      fields <= 4'hF;
      ms(1500);
      fields <= 4'hB;
      ms(1);
      fields <= 4'hF;
      ms(1900);
      `CHECK(pair, 1'b0)
      ms(1200);
      `CHECK(pair, 1'b1)
   endtask : t_modes
   task automatic t_feedback();
      wr(32'h0, 32'h4);
      stuck <= 1'b1;
      fields <= 4'hB;
      ms(310);
      `CHECK(error_code, 8'h35)
      fields <= 4'hF;
      ms(2);
      `CHECK(pair, 1'b0)
      hresetn <= 1'b0;
      stuck <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      wr(32'h0, 32'h14);
      ms(13);
      press <= 1'b1;
      ms(1);
      press <= 1'b0;
      stuck <= 1'b1;
      fields <= 4'hB;
      ms(310);
      `CHECK(leds.reset_required, 1'b1)
      `CHECK(error_code, 8'h35)
   endtask : t_feedback
   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      {hsel, hwrite, htrans, haddr, hwdata, hsize} = '0;
      {stuck, press, n_mismatch, samples_checked} = '0;
      pattern = 4'h5;
      fields = 4'hF;
      hresetn = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_decode();
      t_none();
      t_modes();
      t_feedback();
      conclude();
   end
   initial begin
      repeat (70000) @(posedge hclk);
      n_mismatch++;
      conclude();
   end
endmodule : testbench
